// ==== src/aip_top.sv ====
// Purpose: ram access port with an auto-incrementing address pointer
// Assumes: cpu drives one strobe per cycle, read data one cycle later
// Notes:   fast mode moves bytes between the external bus and ram
//
// Functional notes
// - data port access uses pointer, then increments
// - pointer bytes writable and readable any time
// - pointer reads return the live next address
// - successive data accesses stream like a fifo
// - only internal ram window is reachable
// - fast mode moves a byte within two cycles
// - fast only when enabled and data port accessed
// - 64-byte bulk buffers streamable sequentially

`timescale 1ns/1ps
`default_nettype none

module aip_top
   import aip_pkg::*;
#(
   parameter logic [15:0] RAM_BASE = aip_pkg::RAM_BASE_DEF,
   parameter int          RAM_AW   = aip_pkg::RAM_AW_DEF
)
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [7:0]  reg_rdata,
   input  wire logic [7:0]  ext_data_in,
   output var  logic [7:0]  ext_data_out,
   output var  logic        ext_data_oe_n,
   output var  logic        ext_rd_strobe,
   output var  logic        ext_wr_strobe
);

   import aip_pkg::*;

   // ----------------------------------------------------------------
   // address decode and ram window
   // ----------------------------------------------------------------
   localparam logic [16:0] RAM_LO = {1'b0, RAM_BASE};
   localparam logic [16:0] RAM_HI = 17'(RAM_LO + 17'(2 ** RAM_AW));

   logic [7:0]        fast_ctrl_r;
   logic [7:0]        fast_ctrl_nxt;
   logic [15:0]       ptr_r;
   logic [15:0]       ptr_nxt;
   logic [7:0]        ext_sync1_r;
   logic [7:0]        ext_sync2_r;
   logic              fast_rd_d1_r;
   logic [7:0]        ext_data_out_r;
   logic [7:0]        ext_data_out_nxt;
   logic              ext_data_oe_n_r;
   logic              ext_rd_strobe_r;
   logic              ext_rd_strobe_nxt;
   logic              ext_wr_strobe_r;
   logic              ext_wr_strobe_nxt;
   logic              data_acc;
   logic              fast_en;
   logic              pol;
   logic              fast_rd;
   logic              fast_wr;
   logic              ptr_in_ram;
   logic              ram_we;
   logic              ram_rd;
   logic [RAM_AW-1:0] ram_addr;
   logic [7:0]        ram_wdata;
   logic [7:0]        alt_data;
   logic [15:0]       ptr_off;

   assign data_acc = (reg_wr || reg_rd) && (reg_addr == ADDR_DATA_PORT);
   assign fast_en  = fast_ctrl_r[FAST_BULK_BIT];
   assign pol      = fast_ctrl_r[FAST_POL_BIT];
   assign fast_rd  = data_acc && reg_rd && fast_en;
   assign fast_wr  = data_acc && reg_wr && fast_en;

   // only the internal ram window is a target; other addresses read zero
   assign ptr_in_ram = ({1'b0, ptr_r} >= RAM_LO)
                    && ({1'b0, ptr_r} <  RAM_HI);
   assign ptr_off    = ptr_r - RAM_BASE;
   assign ram_addr   = ptr_off[RAM_AW-1:0];
   assign ram_we     = reg_wr && data_acc && ptr_in_ram;
   assign ram_rd     = reg_rd && data_acc && ptr_in_ram;
   assign ram_wdata  = fast_wr ? ext_sync2_r : reg_wdata;

   // ----------------------------------------------------------------
   // register read mux, registered inside the ram
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (reg_addr)
         ADDR_FAST_CTRL : alt_data = fast_ctrl_r;
         ADDR_PTR_HIGH  : alt_data = ptr_r[15:8];
         ADDR_PTR_LOW   : alt_data = ptr_r[7:0];
         default        : alt_data = READ_ZERO;
      endcase
   end

   aip_ram #(
      .AW       (RAM_AW)
   ) u_ram (
      .clk      (core_clk),
      .we       (ram_we),
      .addr     (ram_addr),
      .wdata    (ram_wdata),
      .mem_rd   (ram_rd),
      .alt_data (alt_data),
      .q        (reg_rdata)
   );

   // ----------------------------------------------------------------
   // control register and pointer
   // ----------------------------------------------------------------
   always_comb
   begin
      fast_ctrl_nxt = fast_ctrl_r;
      ptr_nxt       = ptr_r;
      if (reg_wr && reg_addr == ADDR_FAST_CTRL)
      begin
         fast_ctrl_nxt = reg_wdata & FAST_CTRL_MASK;
      end
      if (reg_wr && reg_addr == ADDR_PTR_HIGH)
      begin
         ptr_nxt[15:8] = reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_PTR_LOW)
      begin
         ptr_nxt[7:0] = reg_wdata;
      end
      if (data_acc)
      begin
         ptr_nxt = ptr_r + PTR_STEP;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         fast_ctrl_r <= FAST_CTRL_RESET;
         ptr_r       <= PTR_RESET;
      end
      else
      begin
         fast_ctrl_r <= fast_ctrl_nxt;
         ptr_r       <= ptr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // external bus side of fast transfers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      ext_sync1_r <= ext_data_in;
      ext_sync2_r <= ext_sync1_r;
   end

   always_comb
   begin
      ext_data_out_nxt  = ext_data_out_r;
      ext_rd_strobe_nxt = fast_wr ? pol : ~pol;
      ext_wr_strobe_nxt = fast_rd_d1_r ? pol : ~pol;
      if (fast_rd_d1_r)
      begin
         ext_data_out_nxt = reg_rdata;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         fast_rd_d1_r    <= 1'b0;
         ext_data_out_r  <= READ_ZERO;
         ext_data_oe_n_r <= 1'b1;
         ext_rd_strobe_r <= 1'b1;
         ext_wr_strobe_r <= 1'b1;
      end
      else
      begin
         fast_rd_d1_r    <= fast_rd;
         ext_data_out_r  <= ext_data_out_nxt;
         ext_data_oe_n_r <= ~fast_rd_d1_r;
         ext_rd_strobe_r <= ext_rd_strobe_nxt;
         ext_wr_strobe_r <= ext_wr_strobe_nxt;
      end
   end

   assign ext_data_out  = ext_data_out_r;
   assign ext_data_oe_n = ext_data_oe_n_r;
   assign ext_rd_strobe = ext_rd_strobe_r;
   assign ext_wr_strobe = ext_wr_strobe_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_ptr_step;
      @(posedge core_clk) disable iff (sys_rst)
      data_acc |=> ptr_r == 16'($past(ptr_r) + 16'h0001);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer did not advance after data access");

   property p_ptr_wrap;
      @(posedge core_clk) disable iff (sys_rst)
      (data_acc && ptr_r == 16'hFFFF) |=> ptr_r == 16'h0000;
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap)
      else $error("pointer did not wrap to zero");

   property p_stream;
      @(posedge core_clk) disable iff (sys_rst)
      data_acc ##1 data_acc |=> ptr_r == 16'($past(ptr_r, 2) + 16'h0002);
   endproperty
   a_stream: assert property (p_stream)
      else $error("back to back data accesses did not stream");

   property p_ptr_load_high;
      @(posedge core_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == ADDR_PTR_HIGH)
         |=> ptr_r[15:8] == $past(reg_wdata);
   endproperty
   a_ptr_load_high: assert property (p_ptr_load_high)
      else $error("pointer high byte not loaded");

   property p_ptr_readback;
      @(posedge core_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_PTR_LOW) |=> reg_rdata == ptr_r[7:0];
   endproperty
   a_ptr_readback: assert property (p_ptr_readback)
      else $error("pointer low byte read back wrong");

   property p_ram_window;
      @(posedge core_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == ADDR_DATA_PORT)
         |-> ram_we == (ptr_r >= RAM_BASE
                        && {1'b0, 16'(ptr_r - RAM_BASE)} < 17'(2 ** RAM_AW));
   endproperty
   a_ram_window: assert property (p_ram_window)
      else $error("ram written outside internal window");

   property p_fast_read;
      @(posedge core_clk) disable iff (sys_rst)
      fast_rd |=> ##1 (!ext_data_oe_n && ext_data_out == $past(reg_rdata)
                       && ext_wr_strobe == pol);
   endproperty
   a_fast_read: assert property (p_fast_read)
      else $error("fast read byte not on external bus in two cycles");

   property p_fast_write;
      @(posedge core_clk) disable iff (sys_rst)
      fast_wr |-> ram_wdata == $past(ext_data_in, 2) ##1 ext_rd_strobe == pol;
   endproperty
   a_fast_write: assert property (p_fast_write)
      else $error("fast write did not take the external byte");

   property p_fast_only;
      @(posedge core_clk) disable iff (sys_rst)
      !ext_data_oe_n |-> $past(fast_rd, 2);
   endproperty
   a_fast_only: assert property (p_fast_only)
      else $error("external bus driven without a fast read");

   property p_no_fast;
      @(posedge core_clk) disable iff (sys_rst)
      (data_acc && !fast_en) |=> ext_rd_strobe != pol ##1 ext_data_oe_n;
   endproperty
   a_no_fast: assert property (p_no_fast)
      else $error("fast transfer while fast bulk disabled");

endmodule : aip_top

`default_nettype wire

// ==== inc/aip_pkg.sv ====
// Purpose: constants shared by the auto-increment ram pointer block
// Assumes: byte-wide register port, 16-bit register addresses
// Notes:   the maximum fast transfer cycle count derives from the core clock period; FAST_XFER_CYC is fixed

package aip_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_FAST_CTRL = 16'h7FE2;
   localparam logic [15:0] ADDR_PTR_HIGH  = 16'h7FE3;
   localparam logic [15:0] ADDR_PTR_LOW   = 16'h7FE4;
   localparam logic [15:0] ADDR_DATA_PORT = 16'h7FE5;

   // ----------------------------------------------------------------
   // fast_transfer_control fields
   // ----------------------------------------------------------------
   localparam int          FAST_BULK_BIT   = 6;
   localparam int          FAST_POL_BIT    = 5;
   localparam int          FAST_MODE_LSB   = 3;
   localparam int          FAST_MODE_MSB   = 4;
   localparam int          ISO_DISABLE_BIT = 0;
   localparam logic [7:0]  FAST_CTRL_MASK  = 8'h79;
   localparam logic [7:0]  FAST_CTRL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // pointer and ram window
   // ----------------------------------------------------------------
   localparam logic [15:0] PTR_RESET    = 16'h0000;
   localparam logic [15:0] PTR_STEP     = 16'h0001;
   localparam logic [15:0] RAM_BASE_DEF = 16'h0000;
   localparam int          RAM_AW_DEF   = 13;
   localparam int          BULK_BUF_BYTES = 64;
   localparam logic [7:0]  READ_ZERO    = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 4;
   localparam int FAST_XFER_TIME_NS = 333;
   localparam int FAST_XFER_MAX_CYC = FAST_XFER_TIME_NS / CLK_PERIOD_NS;
   localparam int FAST_XFER_CYC     = 2;

endpackage : aip_pkg

// ==== src/aip_ram.sv ====
// Purpose: internal program/data ram behind the pointer port
// Assumes: one access per cycle, registered read data
// Notes:   when mem_rd is low the register takes alt_data instead

`timescale 1ns/1ps
`default_nettype none

module aip_ram
#(
   parameter int AW = 13
)
(
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   input  wire logic          mem_rd,
   input  wire logic [7:0]    alt_data,
   output var  logic [7:0]    q
);

   logic [7:0] mem [0:(2**AW)-1];
   logic [7:0] q_r;

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      q_r <= mem_rd ? mem[addr] : alt_data;
   end

   assign q = q_r;

endmodule : aip_ram

`default_nettype wire

// ==== tb/aip_ext_model.sv ====
// Purpose: external bus device seen by fast transfers
// Assumes: strobe active level equals pol
// Notes:   an undriven input bus shows a toggling pattern
`timescale 1ns/1ps
`default_nettype none

module aip_ext_model
(
   input  wire logic       core_clk,
   input  wire logic       pol,
   input  wire logic       drv,
   input  wire logic [7:0] src,
   input  wire logic [7:0] ext_data_out,
   input  wire logic       ext_data_oe_n,
   input  wire logic       ext_rd_strobe,
   input  wire logic       ext_wr_strobe,
   output var  logic [7:0] ext_data_in,
   output var  logic [7:0] got,
   output var  int         n_rd,
   output var  int         n_wr
);
   initial
   begin
      ext_data_in = 8'h5A;
      got = 8'h00;
      n_rd = 0;
      n_wr = 0;
   end

   always @(posedge core_clk)
   begin
      ext_data_in <= drv ? src : ~ext_data_in;
      if (ext_rd_strobe === pol)
         n_rd <= n_rd + 1;
      if (ext_wr_strobe === pol && ext_data_oe_n === 1'b0)
      begin
         got  <= ext_data_out;
         n_wr <= n_wr + 1;
      end
   end
endmodule : aip_ext_model
`default_nettype wire

// ==== tb/aip_top_tb.sv ====
// Purpose: self-checking bench for the pointer port
// Assumes: default ram window, one strobe per cycle
// Notes:   expectations come from a queue-free integer model
`timescale 1ns/1ps
`default_nettype none

module aip_top_tb;
   import aip_pkg::*;
   logic        core_clk, sys_rst, reg_wr, reg_rd, drv;
   logic [15:0] reg_addr, ptr;
   logic [7:0]  reg_wdata, reg_rdata, ext_data_in, ext_data_out;
   logic        ext_data_oe_n, ext_rd_strobe, ext_wr_strobe;
   logic [7:0]  src, got, ctl, seed;
   logic [7:0]  mem [int];
   int          n_rd, n_wr, k, n_fail, checks_done;

   aip_top #(
      .RAM_BASE      (RAM_BASE_DEF),
      .RAM_AW        (RAM_AW_DEF)
   ) dut (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .ext_data_in   (ext_data_in),
      .ext_data_out  (ext_data_out),
      .ext_data_oe_n (ext_data_oe_n),
      .ext_rd_strobe (ext_rd_strobe),
      .ext_wr_strobe (ext_wr_strobe)
   );
   aip_ext_model ext (.core_clk(core_clk), .pol(ctl[FAST_POL_BIT]),
      .drv(drv), .src(src), .ext_data_out(ext_data_out),
      .ext_data_oe_n(ext_data_oe_n), .ext_rd_strobe(ext_rd_strobe),
      .ext_wr_strobe(ext_wr_strobe), .ext_data_in(ext_data_in),
      .got(got), .n_rd(n_rd), .n_wr(n_wr));

   always #2 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // bus tasks and model
   // ----------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic bit in_win(input logic [15:0] a);
      return a >= RAM_BASE_DEF && a < RAM_BASE_DEF + (1 << RAM_AW_DEF);
   endfunction : in_win

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      if (a == ADDR_PTR_HIGH)
         ptr[15:8] = d;
      if (a == ADDR_PTR_LOW)
         ptr[7:0] = d;
      if (a == ADDR_FAST_CTRL)
         ctl = d & FAST_CTRL_MASK;
      if (a == ADDR_DATA_PORT)
      begin
         if (in_win(ptr))
            mem[ptr] = ctl[FAST_BULK_BIT] ? src : d;
         ptr = ptr + PTR_STEP;
      end
   endtask : wr

   task automatic rd(input logic [15:0] a, input string nm);
      logic [7:0] e;
      e = READ_ZERO;
      if (a == ADDR_PTR_HIGH)
         e = ptr[15:8];
      if (a == ADDR_PTR_LOW)
         e = ptr[7:0];
      if (a == ADDR_FAST_CTRL)
         e = ctl;
      if (a == ADDR_DATA_PORT && in_win(ptr))
         e = mem[ptr];
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, e, reg_rdata);
      if (a == ADDR_DATA_PORT)
         ptr = ptr + PTR_STEP;
   endtask : rd

   // two data port reads with no gap between the strobes
   task automatic rd2(input string nm);
      logic [7:0] e0;
      logic [7:0] e1;
      e0 = in_win(ptr) ? mem[ptr] : READ_ZERO;
      e1 = in_win(ptr + PTR_STEP) ? mem[ptr + PTR_STEP] : READ_ZERO;
      @(posedge core_clk);
      reg_addr <= ADDR_DATA_PORT;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      #1;
      chk(nm, e0, reg_rdata);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, e1, reg_rdata);
      ptr = ptr + PTR_STEP + PTR_STEP;
   endtask : rd2

   task automatic end_sim();
      if (n_fail == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 0;
      sys_rst = 1;
      {reg_wr, reg_rd, drv} = 3'b000;
      {reg_addr, reg_wdata, src} = 32'h0000_0000;
      {ptr, ctl, seed} = {PTR_RESET, FAST_CTRL_RESET, 8'h61};
      {n_fail, checks_done} = 0;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(ADDR_FAST_CTRL, "ctl_reset");
      rd(ADDR_PTR_HIGH, "ptr_reset");
      wr(ADDR_PTR_HIGH, 8'h12);
      wr(ADDR_PTR_LOW, 8'hC0);
      rd(ADDR_PTR_LOW, "ptr_low");
      for (int i = 0; i < BULK_BUF_BYTES; i++)
      begin
         seed = lfsr(seed);
         wr(ADDR_DATA_PORT, seed);
      end
      rd(ADDR_PTR_HIGH, "ptr_carry_hi");
      rd(ADDR_PTR_LOW, "ptr_carry_lo");
      wr(ADDR_PTR_LOW, 8'hC0);
      wr(ADDR_PTR_HIGH, 8'h12);
      for (int i = 0; i < BULK_BUF_BYTES; i++)
         rd(ADDR_DATA_PORT, "stream");
      rd(ADDR_PTR_LOW, "ptr_live");
      wr(ADDR_PTR_LOW, 8'hF0);
      wr(ADDR_PTR_HIGH, 8'h12);
      repeat (4) rd2("burst");
      wr(ADDR_PTR_HIGH, 8'hFF);
      wr(ADDR_PTR_LOW, 8'hFF);
      wr(ADDR_DATA_PORT, 8'hA5);
      rd(ADDR_PTR_HIGH, "ptr_wrap");
      wr(ADDR_PTR_HIGH, 8'h20);
      rd(ADDR_DATA_PORT, "outside");
      rd(16'h7FE0, "unmapped");
      for (int p = 0; p < 2; p++)
      begin
         wr(ADDR_FAST_CTRL, p ? 8'h60 : 8'h40);
         rd(ADDR_FAST_CTRL, "fast_ctl");
         wr(ADDR_PTR_HIGH, 8'h01);
         wr(ADDR_PTR_LOW, 8'h00);
         seed = lfsr(seed);
         src <= seed;
         drv <= 1'b1;
         repeat (4) @(posedge core_clk);
         k = n_rd;
         wr(ADDR_DATA_PORT, 8'h00);
         repeat (2) @(posedge core_clk);
         #1;
         chk("fetch_strobe", 8'h01, 8'(n_rd - k));
         drv <= 1'b0;
         wr(ADDR_PTR_LOW, 8'h00);
         k = n_wr;
         rd(ADDR_DATA_PORT, "fast_rd");
         repeat (2) @(posedge core_clk);
         #1;
         chk("ext_byte", seed, got);
         chk("store_strobe", 8'h01, 8'(n_wr - k));
      end
      wr(ADDR_FAST_CTRL, 8'h00);
      repeat (3) @(posedge core_clk);
      k = n_rd + n_wr;
      wr(ADDR_DATA_PORT, 8'h3C);
      wr(ADDR_PTR_LOW, 8'h01);
      rd(ADDR_DATA_PORT, "no_fast");
      repeat (3) @(posedge core_clk);
      #1;
      chk("no_strobe", 8'h00, 8'(n_rd + n_wr - k));
      end_sim();
   end

   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      end_sim();
   end
endmodule : aip_top_tb
`default_nettype wire
